// ---- design/maco_accum_ops.sv ----
// accumulator register, accumulator file and their five-cycle operations
`timescale 1ns/1ps
`default_nettype none
module maco_accum_ops #(
    parameter int ENTRIES = maco_pkg::ENTRIES
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic                 issueValid,
    input  wire maco_pkg::maco_op_t   issueOp,
    input  wire logic [1:0]           issueSize,
    input  wire logic                 issueSignA,
    input  wire logic                 issueSignB,
    input  wire logic [31:0]          issueOpA,
    input  wire logic [31:0]          issueOpB,
    input  wire logic [6:0]           issueRdAddr,
    input  wire logic [6:0]           issueWrAddr,
    input  wire logic                 ctlRead,
    input  wire logic                 ctlWrite,
    input  wire logic                 ctlAccu,
    input  wire logic                 ctlAddrInc,
    input  wire logic                 crWrEn,
    input  wire logic                 crWrSel,
    input  wire logic [31:0]          crWrData,
    output logic      [31:0]          accumPart0,
    output logic      [31:0]          accumPart1,
    output logic      [63:0]          mResult,
    output logic                      mValid
);
    typedef maco_pkg::maco_op_t maco_sop_t;

    logic [63:0] accMem [ENTRIES];
    logic [63:0] accum_ff, nxt_accum;
    logic [63:0] mResult_ff, nxt_mResult;
    logic        mValid_ff, nxt_mValid;
    logic [1:0]  lastSize_ff, nxt_lastSize;
    logic        lastSignA_ff, nxt_lastSignA;
    logic        lastSignB_ff, nxt_lastSignB;
    logic [6:0]  rdPtr_ff, nxt_rdPtr;
    logic [6:0]  wrPtr_ff, nxt_wrPtr;
    logic        vld_ff [1:4];
    logic        nxt_vld [1:4];
    maco_sop_t   op_ff [1:4];
    maco_sop_t   nxt_op [1:4];
    logic [1:0]  sz_ff [1:4];
    logic [1:0]  nxt_sz [1:4];
    logic [2:0]  ctl_ff [1:4];
    logic [2:0]  nxt_ctl [1:4];
    logic [6:0]  wa_ff [1:4];
    logic [6:0]  nxt_wa [1:4];
    logic [63:0] prod_ff [1:2];
    logic [63:0] nxt_prod [1:2];
    logic [63:0] cross_ff [1:2];
    logic [63:0] nxt_cross [1:2];
    logic [63:0] rd_ff [1:2];
    logic [63:0] nxt_rd2;
    logic [1:0]  mulSize;
    logic        mulSignA;
    logic        mulSignB;
    logic        useInc;
    logic [6:0]  rdAddr;
    logic [6:0]  wrAddr;
    logic        memWrEn;
    logic [63:0] mulProd;
    logic [63:0] mulCross;

    // lane-wise add; carries stop at lane edges
    function automatic logic [63:0] laneAdd(input logic [63:0] x,
                                            input logic [63:0] y,
                                            input logic [1:0]  sz);
        logic [63:0] r;
        r = x + y;
        if (sz == maco_pkg::SZ_16) begin
            r[63:32] = x[63:32] + y[63:32];
            r[31:0]  = x[31:0] + y[31:0];
        end else if (sz == maco_pkg::SZ_8) begin
            for (int k = 0; k < 4; k++) begin
                r[16*k +: 16] = x[16*k +: 16] + y[16*k +: 16];
            end
        end
        return r;
    endfunction

    always_comb begin
        mulSize  = issueSize;
        mulSignA = issueSignA;
        mulSignB = issueSignB;
        if (issueOp == maco_pkg::OP_MACS || issueOp == maco_pkg::OP_MACB) begin
            mulSize  = lastSize_ff;
            mulSignA = lastSignA_ff;
            mulSignB = lastSignB_ff;
        end else if (issueOp == maco_pkg::OP_VECT
                     || issueOp == maco_pkg::OP_CPLX) begin
            mulSize = maco_pkg::SZ_16;
        end
        useInc = issueOp == maco_pkg::OP_MACB && ctlAddrInc;
        rdAddr = useInc ? rdPtr_ff : issueRdAddr;
        wrAddr = useInc ? wrPtr_ff : issueWrAddr;
    end

    // straight products and half-swapped cross products
    maco_lane_mul u_mulMain (
        .opA   (issueOpA),
        .opB   (issueOpB),
        .size  (mulSize),
        .signA (mulSignA),
        .signB (mulSignB),
        .prod  (mulProd)
    );
    maco_lane_mul u_mulCross (
        .opA   (issueOpA),
        .opB   ({issueOpB[15:0], issueOpB[31:16]}),
        .size  (maco_pkg::SZ_16),
        .signA (mulSignA),
        .signB (mulSignB),
        .prod  (mulCross)
    );

    always_comb begin
        logic [63:0] base;
        base          = accum_ff;
        nxt_accum     = accum_ff;
        nxt_mResult   = mResult_ff;
        nxt_mValid    = 1'b0;
        nxt_lastSize  = lastSize_ff;
        nxt_lastSignA = lastSignA_ff;
        nxt_lastSignB = lastSignB_ff;
        nxt_rdPtr     = rdPtr_ff;
        nxt_wrPtr     = wrPtr_ff;
        // five-cycle pipe, one issue per cycle
        nxt_vld[1] = issueValid;
        nxt_op[1]  = issueOp;
        nxt_sz[1]  = mulSize;
        nxt_ctl[1] = {ctlAccu, ctlWrite, ctlRead};
        nxt_wa[1]  = (issueOp == maco_pkg::OP_STORE) ? issueWrAddr : wrAddr;
        for (int k = 2; k <= 4; k++) begin
            nxt_vld[k] = vld_ff[k-1];
            nxt_op[k]  = op_ff[k-1];
            nxt_sz[k]  = sz_ff[k-1];
            nxt_ctl[k] = ctl_ff[k-1];
            nxt_wa[k]  = wa_ff[k-1];
        end
        nxt_prod[1]  = mulProd;
        nxt_prod[2]  = prod_ff[1];
        nxt_cross[1] = mulCross;
        nxt_cross[2] = cross_ff[1];
        nxt_rd2      = rd_ff[1];
        if (issueValid && issueOp == maco_pkg::OP_MUL) begin
            nxt_lastSize  = issueSize;
            nxt_lastSignA = issueSignA;
            nxt_lastSignB = issueSignB;
        end
        if (issueValid && issueOp == maco_pkg::OP_MACB) begin
            nxt_rdPtr = rdAddr + 7'h1;
            nxt_wrPtr = wrAddr + 7'h1;
        end
        // results land at the end of cycle three, seen in cycle four
        if (vld_ff[2]) begin
            nxt_mValid = op_ff[2] != maco_pkg::OP_STORE;
            case (op_ff[2])
                maco_pkg::OP_LOAD: nxt_accum = rd_ff[2];
                maco_pkg::OP_STEP:
                    nxt_accum = laneAdd(accum_ff, rd_ff[2], sz_ff[2]);
                maco_pkg::OP_MACS:
                    nxt_accum = laneAdd(accum_ff, prod_ff[2], sz_ff[2]);
                maco_pkg::OP_MACB: begin
                    base = ctl_ff[2][maco_pkg::CTL_RD] ? rd_ff[2] : accum_ff;
                    nxt_accum = ctl_ff[2][maco_pkg::CTL_ACC]
                              ? laneAdd(base, prod_ff[2], sz_ff[2])
                              : prod_ff[2];
                end
                default: nxt_accum = accum_ff;
            endcase
            case (op_ff[2])
                maco_pkg::OP_MUL:   nxt_mResult = prod_ff[2];
                maco_pkg::OP_VECT: begin
                    nxt_mResult[63:32] = prod_ff[2][63:32] + prod_ff[2][31:0];
                    nxt_mResult[31:0]  = cross_ff[2][63:32]
                                       - cross_ff[2][31:0];
                end
                maco_pkg::OP_CPLX: begin
                    nxt_mResult[63:32] = prod_ff[2][63:32] - prod_ff[2][31:0];
                    nxt_mResult[31:0]  = cross_ff[2][63:32]
                                       + cross_ff[2][31:0];
                end
                maco_pkg::OP_STORE: nxt_mResult = mResult_ff;
                default:            nxt_mResult = nxt_accum;
            endcase
        end else if (crWrEn) begin
            if (crWrSel == maco_pkg::CR_PART1) begin
                nxt_accum[63:32] = crWrData;
            end else begin
                nxt_accum[31:0] = crWrData;
            end
        end
        // file write during cycle five
        memWrEn = vld_ff[4] && (op_ff[4] == maco_pkg::OP_STORE
                  || (op_ff[4] == maco_pkg::OP_MACB
                      && ctl_ff[4][maco_pkg::CTL_WR]));
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            accum_ff     <= maco_pkg::ACC_RST;
            mResult_ff   <= maco_pkg::ACC_RST;
            mValid_ff    <= 1'b0;
            lastSize_ff  <= maco_pkg::SZ_32;
            lastSignA_ff <= 1'b0;
            lastSignB_ff <= 1'b0;
            rdPtr_ff     <= 7'h0;
            wrPtr_ff     <= 7'h0;
            for (int k = 1; k <= 4; k++) begin
                vld_ff[k] <= 1'b0;
                op_ff[k]  <= maco_pkg::OP_MUL;
                sz_ff[k]  <= maco_pkg::SZ_32;
                ctl_ff[k] <= 3'h0;
                wa_ff[k]  <= 7'h0;
            end
            for (int k = 1; k <= 2; k++) begin
                prod_ff[k]  <= 64'h0;
                cross_ff[k] <= 64'h0;
            end
        end else begin
            accum_ff     <= nxt_accum;
            mResult_ff   <= nxt_mResult;
            mValid_ff    <= nxt_mValid;
            lastSize_ff  <= nxt_lastSize;
            lastSignA_ff <= nxt_lastSignA;
            lastSignB_ff <= nxt_lastSignB;
            rdPtr_ff     <= nxt_rdPtr;
            wrPtr_ff     <= nxt_wrPtr;
            vld_ff       <= nxt_vld;
            op_ff        <= nxt_op;
            sz_ff        <= nxt_sz;
            ctl_ff       <= nxt_ctl;
            wa_ff        <= nxt_wa;
            prod_ff      <= nxt_prod;
            cross_ff     <= nxt_cross;
        end
    end

    // accumulator file, synchronous read in cycle one
    always_ff @(posedge core_clk) begin
        rd_ff[1] <= accMem[rdAddr];
        rd_ff[2] <= nxt_rd2;
        if (memWrEn) begin
            accMem[wa_ff[4]] <= accum_ff;
        end
    end

    assign accumPart0 = accum_ff[31:0];
    assign accumPart1 = accum_ff[63:32];
    assign mResult    = mResult_ff;
    assign mValid     = mValid_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_LOAD_DATA: assert property (
        vld_ff[2] && op_ff[2] == maco_pkg::OP_LOAD
        |=> accum_ff == $past(rd_ff[2]))
        else $error("load did not copy file word");
    AST_LOAD_CYCLE4: assert property (
        issueValid && issueOp == maco_pkg::OP_LOAD |-> ##3 mValid_ff)
        else $error("load result not seen in cycle four");
    AST_LOAD_B2B: assert property (
        issueValid && issueOp == maco_pkg::OP_LOAD
        ##1 issueValid && issueOp == maco_pkg::OP_LOAD
        |-> ##2 mValid_ff [*2])
        else $error("back to back loads not both done");
    AST_STORE_CYCLE5: assert property (
        issueValid && issueOp == maco_pkg::OP_STORE |-> ##4 memWrEn)
        else $error("store write not in cycle five");
    AST_STORE_DATA: assert property (
        memWrEn |=> accMem[$past(wa_ff[4])] == $past(accum_ff))
        else $error("file word differs from accumulator");
    AST_STORE_B2B: assert property (
        issueValid && issueOp == maco_pkg::OP_STORE
        ##1 issueValid && issueOp == maco_pkg::OP_STORE
        |-> ##3 memWrEn [*2])
        else $error("back to back stores not both written");
    AST_CR_PART: assert property (
        crWrEn && !vld_ff[2] && crWrSel == maco_pkg::CR_PART1
        |=> accumPart1 == $past(crWrData) && $stable(accumPart0))
        else $error("control register write lost");
    AST_STEP_Q8: assert property (
        vld_ff[2] && op_ff[2] == maco_pkg::OP_STEP
        && sz_ff[2] == maco_pkg::SZ_8
        |=> accum_ff[15:0] == 16'($past(accum_ff[15:0]) + $past(rd_ff[2][15:0]))
            && accum_ff[31:16]
               == 16'($past(accum_ff[31:16]) + $past(rd_ff[2][31:16])))
        else $error("byte step lane carried or lost");
    AST_MACS_SIZE: assert property (
        issueValid && issueOp == maco_pkg::OP_MACS
        |=> sz_ff[1] == $past(lastSize_ff))
        else $error("scalar mac ignored last multiply size");
    AST_VECT: assert property (
        issueValid && issueOp == maco_pkg::OP_VECT && issueSignA && issueSignB
        |-> ##3 mResult_ff[63:32] == 32'(
            $signed($past(issueOpA[31:16], 3)) * $signed($past(issueOpB[31:16], 3))
          + $signed($past(issueOpA[15:0], 3)) * $signed($past(issueOpB[15:0], 3))))
        else $error("vector dot product wrong");
    AST_CPLX: assert property (
        issueValid && issueOp == maco_pkg::OP_CPLX && issueSignA && issueSignB
        |-> ##3 mResult_ff[31:0] == 32'(
            $signed($past(issueOpA[31:16], 3)) * $signed($past(issueOpB[15:0], 3))
          + $signed($past(issueOpA[15:0], 3)) * $signed($past(issueOpB[31:16], 3))))
        else $error("complex imaginary part wrong");

    COV_LOAD_STORE: cover property (
        issueValid && issueOp == maco_pkg::OP_LOAD
        ##1 issueValid && issueOp == maco_pkg::OP_STORE);
    COV_MACB_INC: cover property (
        issueValid && issueOp == maco_pkg::OP_MACB && ctlAddrInc && ctlWrite);
    COV_STEP_Q8: cover property (
        vld_ff[2] && op_ff[2] == maco_pkg::OP_STEP && sz_ff[2] == maco_pkg::SZ_8);
endmodule
`default_nettype wire

// ---- include/maco_pkg.sv ----
// constants and types of the accumulator-side multiplier datapath
package maco_pkg;
    localparam int          ACC_W     = 64;
    localparam int          OPND_W    = 32;
    localparam int          ENTRIES   = 128;
    localparam int          ADDR_W    = 7;
    localparam int          STAGES    = 4;
    localparam int          ACC_STAGE = 2;
    localparam int          WR_STAGE  = 4;
    localparam logic [1:0]  SZ_32     = 2'h0;
    localparam logic [1:0]  SZ_16     = 2'h1;
    localparam logic [1:0]  SZ_8      = 2'h2;
    localparam logic [63:0] ACC_RST   = 64'h0;
    localparam logic        CR_PART0  = 1'b0;
    localparam logic        CR_PART1  = 1'b1;
    localparam int          CTL_RD    = 0;
    localparam int          CTL_WR    = 1;
    localparam int          CTL_ACC   = 2;
    typedef enum logic [7:0] {
        OP_MUL   = 8'h01,
        OP_LOAD  = 8'h02,
        OP_STORE = 8'h04,
        OP_STEP  = 8'h08,
        OP_MACS  = 8'h10,
        OP_MACB  = 8'h20,
        OP_VECT  = 8'h40,
        OP_CPLX  = 8'h80
    } maco_op_t;
endpackage

// ---- design/maco_lane_mul.sv ----
// lane-wise basic multiplier: one 32, two 16 or four 8 bit products
`timescale 1ns/1ps
`default_nettype none
module maco_lane_mul (
    input  wire logic [31:0] opA,
    input  wire logic [31:0] opB,
    input  wire logic [1:0]  size,
    input  wire logic        signA,
    input  wire logic        signB,
    output logic      [63:0] prod
);
    logic [63:0] prod32;
    logic [63:0] prod16;
    logic [63:0] prod8;
    logic [65:0] full32;

    assign full32 = 66'($signed({signA & opA[31], opA})
                  * $signed({signB & opB[31], opB}));
    assign prod32 = full32[63:0];

    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            logic [33:0] p;
            assign p = 34'($signed({signA & opA[16*h+15], opA[16*h +: 16]})
                     * $signed({signB & opB[16*h+15], opB[16*h +: 16]}));
            assign prod16[32*h +: 32] = p[31:0];
        end
        for (h = 0; h < 4; h++) begin : g_byte
            logic [17:0] p;
            assign p = 18'($signed({signA & opA[8*h+7], opA[8*h +: 8]})
                     * $signed({signB & opB[8*h+7], opB[8*h +: 8]}));
            assign prod8[16*h +: 16] = p[15:0];
        end
    endgenerate

    always_comb begin
        case (size)
            maco_pkg::SZ_16: prod = prod16;
            maco_pkg::SZ_8:  prod = prod8;
            default:         prod = prod32;
        endcase
    end
endmodule
`default_nettype wire

// ---- dv/maco_issue_model.sv ----
// issue-side model that drives instructions and control register writes
`timescale 1ns/1ps
`default_nettype none
module maco_issue_model (
    input  wire logic             core_clk,
    output logic                  issueValid,
    output var maco_pkg::maco_op_t issueOp,
    output logic [1:0]            issueSize,
    output logic                  issueSignA,
    output logic                  issueSignB,
    output logic [31:0]           issueOpA,
    output logic [31:0]           issueOpB,
    output logic [6:0]            issueRdAddr,
    output logic [6:0]            issueWrAddr,
    output logic                  ctlRead,
    output logic                  ctlWrite,
    output logic                  ctlAccu,
    output logic                  ctlAddrInc,
    output logic                  crWrEn,
    output logic                  crWrSel,
    output logic [31:0]           crWrData
);
    initial begin
        {issueValid, issueSize, issueSignA, issueSignB} = '0;
        issueOp = maco_pkg::OP_MUL;
        {issueOpA, issueOpB, issueRdAddr, issueWrAddr} = '0;
        {ctlRead, ctlWrite, ctlAccu, ctlAddrInc} = '0;
        {crWrEn, crWrSel, crWrData} = '0;
    end

    // one instruction per cycle, valid held between calls
    task automatic issue(input maco_pkg::maco_op_t op,
        input logic [1:0] sz, input logic sa, input logic sb,
        input logic [31:0] a, input logic [31:0] b,
        input logic [6:0] rd, input logic [6:0] wr, input logic [3:0] c);
        @(posedge core_clk);
        issueValid  <= 1'b1;
        issueOp     <= op;
        issueSize   <= sz;
        issueSignA  <= sa;
        issueSignB  <= sb;
        issueOpA    <= a;
        issueOpB    <= b;
        issueRdAddr <= rd;
        issueWrAddr <= wr;
        ctlRead     <= c[maco_pkg::CTL_RD];
        ctlWrite    <= c[maco_pkg::CTL_WR];
        ctlAccu     <= c[maco_pkg::CTL_ACC];
        ctlAddrInc  <= c[3];
    endtask

    task automatic idle();
        @(posedge core_clk);
        issueValid <= 1'b0;
    endtask

    task automatic crWrite(input logic sel, input logic [31:0] d);
        @(posedge core_clk);
        crWrEn   <= 1'b1;
        crWrSel  <= sel;
        crWrData <= d;
        @(posedge core_clk);
        crWrEn   <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- dv/maco_accum_ops_tb.sv ----
// self-checking bench of the accumulator datapath
`timescale 1ns/1ps
`default_nettype none
module maco_accum_ops_tb;
    logic               core_clk;
    logic               reset;
    logic               issueValid;
    maco_pkg::maco_op_t issueOp;
    logic [1:0]         issueSize;
    logic               issueSignA;
    logic               issueSignB;
    logic [31:0]        issueOpA;
    logic [31:0]        issueOpB;
    logic [6:0]         issueRdAddr;
    logic [6:0]         issueWrAddr;
    logic               ctlRead;
    logic               ctlWrite;
    logic               ctlAccu;
    logic               ctlAddrInc;
    logic               crWrEn;
    logic               crWrSel;
    logic [31:0]        crWrData;
    logic [31:0]        accumPart0;
    logic [31:0]        accumPart1;
    logic [63:0]        mResult;
    logic               mValid;
    int                 mismatches = 0;
    int                 testsRun = 0;

    maco_accum_ops u_maco_accum_ops (.core_clk(core_clk), .reset(reset),
        .issueValid(issueValid), .issueOp(issueOp), .issueSize(issueSize),
        .issueSignA(issueSignA), .issueSignB(issueSignB),
        .issueOpA(issueOpA), .issueOpB(issueOpB),
        .issueRdAddr(issueRdAddr), .issueWrAddr(issueWrAddr),
        .ctlRead(ctlRead), .ctlWrite(ctlWrite), .ctlAccu(ctlAccu),
        .ctlAddrInc(ctlAddrInc), .crWrEn(crWrEn), .crWrSel(crWrSel),
        .crWrData(crWrData), .accumPart0(accumPart0),
        .accumPart1(accumPart1), .mResult(mResult), .mValid(mValid));

    maco_issue_model u_maco_issue_model (.core_clk(core_clk),
        .issueValid(issueValid), .issueOp(issueOp), .issueSize(issueSize),
        .issueSignA(issueSignA), .issueSignB(issueSignB),
        .issueOpA(issueOpA), .issueOpB(issueOpB),
        .issueRdAddr(issueRdAddr), .issueWrAddr(issueWrAddr),
        .ctlRead(ctlRead), .ctlWrite(ctlWrite), .ctlAccu(ctlAccu),
        .ctlAddrInc(ctlAddrInc), .crWrEn(crWrEn), .crWrSel(crWrSel),
        .crWrData(crWrData));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        testsRun++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("mismatches=%0d tests_run=%0d", mismatches, testsRun);
        if (mismatches == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // lane products, each the low double width of a sign-extended pair
    function automatic logic [63:0] mulx(input logic [31:0] a,
        input logic [31:0] b, input logic [1:0] sz, input logic sa,
        input logic sb);
        int          w;
        logic [63:0] r, x, y, m;
        w = (sz == maco_pkg::SZ_8) ? 8 : (sz == maco_pkg::SZ_16) ? 16 : 32;
        m = (64'h1 << w) - 64'h1;
        r = '0;
        for (int k = 0; k < 32 / w; k++) begin
            x = (64'(a) >> (k * w)) & m;
            y = (64'(b) >> (k * w)) & m;
            if (sa && x[w-1]) x = x | ~m;
            if (sb && y[w-1]) y = y | ~m;
            r = r | (((x * y) & ((m << w) | m)) << (2 * k * w));
        end
        return r;
    endfunction

    // lane-wise add, no carry between lanes
    function automatic logic [63:0] laneAdd(input logic [63:0] a,
        input logic [63:0] b, input logic [1:0] sz);
        int          w;
        logic [63:0] r, m;
        w = (sz == maco_pkg::SZ_8) ? 16 : (sz == maco_pkg::SZ_16) ? 32 : 64;
        m = (w == 64) ? '1 : (64'h1 << w) - 64'h1;
        r = '0;
        for (int s = 0; s < 64; s += w)
            r = r | ((((a >> s) + (b >> s)) & m) << s);
        return r;
    endfunction

    task automatic wr64(input logic [63:0] v);
        u_maco_issue_model.crWrite(maco_pkg::CR_PART0, v[31:0]);
        u_maco_issue_model.crWrite(maco_pkg::CR_PART1, v[63:32]);
        @(posedge core_clk);
        #1;
        check({accumPart1, accumPart0}, v);
    endtask

    task automatic do1(input maco_pkg::maco_op_t op, input logic [1:0] sz,
        input logic sa, input logic sb, input logic [31:0] a,
        input logic [31:0] b, input logic [6:0] rd, input logic [6:0] wr,
        input logic [3:0] c, input logic [63:0] exp);
        u_maco_issue_model.issue(op, sz, sa, sb, a, b, rd, wr, c);
        u_maco_issue_model.idle();
        repeat (2) @(posedge core_clk);
        #1;
        check({63'h0, mValid}, 64'h1);
        check(mResult, exp);
        if (op != maco_pkg::OP_MUL && op != maco_pkg::OP_VECT &&
            op != maco_pkg::OP_CPLX)
            check({accumPart1, accumPart0}, exp);
        @(posedge core_clk);
        #1;
        check({63'h0, mValid}, 64'h0);
    endtask

    task automatic st(input logic [6:0] ad);
        u_maco_issue_model.issue(maco_pkg::OP_STORE, 2'h0, 1'b0, 1'b0,
            32'h0, 32'h0, 7'h00, ad, 4'h0);
        u_maco_issue_model.idle();
        repeat (3) @(posedge core_clk);
        #1;
        check({63'h0, mValid}, 64'h0);
        repeat (4) @(posedge core_clk);
    endtask

    task automatic t_store_load();
        logic [63:0] v [7] = '{64'h0123_4567_89AB_CDEF,
            64'hFEDC_BA98_7654_3210, 64'h8000_0000_0000_0001,
            64'h5A5A_A5A5_0F0F_F0F0, 64'h5A5A_A5A5_0F0F_F0F0,
            64'h5A5A_A5A5_0F0F_F0F0, 64'h0123_4567_89AB_CDEF};
        logic [6:0]  ad [7] = '{7'h00, 7'h01, 7'h7F, 7'h04, 7'h05, 7'h06,
            7'h00};
        for (int i = 0; i < 3; i++) begin
            wr64(v[i]);
            st(ad[i]);
        end
        wr64(v[3]);
        for (int i = 3; i < 6; i++)
            u_maco_issue_model.issue(maco_pkg::OP_STORE, 2'h0, 1'b0, 1'b0,
                32'h0, 32'h0, 7'h00, ad[i], 4'h0);
        u_maco_issue_model.idle();
        repeat (8) @(posedge core_clk);
        wr64(v[3]);
        st(7'h00);
        v[0] = v[3];
        v[6] = v[3];
        // each load result checked in its fourth cycle
        for (int i = 0; i < 10; i++) begin
            if (i < 7)
                u_maco_issue_model.issue(maco_pkg::OP_LOAD, 2'h0, 1'b0,
                    1'b0, 32'h0, 32'h0, ad[i], 7'h00, 4'h0);
            else
                u_maco_issue_model.idle();
            if (i >= 3) begin
                #1;
                check({63'h0, mValid}, 64'h1);
                check(mResult, v[i-3]);
                check({accumPart1, accumPart0}, v[i-3]);
            end
        end
        // store then load of the same word exactly at the write edge
        wr64(v[2]);
        u_maco_issue_model.issue(maco_pkg::OP_STORE, 2'h0, 1'b0, 1'b0,
            32'h0, 32'h0, 7'h00, 7'h01, 4'h0);
        u_maco_issue_model.idle();
        repeat (2) @(posedge core_clk);
        do1(maco_pkg::OP_LOAD, 2'h0, 1'b0, 1'b0, 32'h0, 32'h0, 7'h01,
            7'h00, 4'h0, v[1]);
        do1(maco_pkg::OP_LOAD, 2'h0, 1'b0, 1'b0, 32'h0, 32'h0, 7'h01,
            7'h00, 4'h0, v[2]);
    endtask

    task automatic t_step();
        logic [63:0] e;
        wr64(64'h0001_0001_0080_0001);
        st(7'h14);
        e = 64'h0001_FFFF_0080_1234;
        wr64(e);
        // three steps as a first-order interpolation
        for (int i = 2; i >= 0; i--) begin
            e = laneAdd(e, 64'h0001_0001_0080_0001, 2'(i));
            do1(maco_pkg::OP_STEP, 2'(i), 1'b0, 1'b0, 32'h0, 32'h0, 7'h14,
                7'h00, 4'h0, e);
        end
    endtask

    task automatic t_mul_macs();
        logic [31:0] a = 32'hF3A5_8E71, b = 32'h9C4B_E2D7;
        logic [31:0] c = 32'h0123_80FF, d = 32'hFE01_7F80;
        logic [63:0] acc = 64'h7FFF_8001_FFF0_0010;
        logic        sa, sb;
        for (int i = 0; i < 3; i++) begin
            sa = (i != 1);
            sb = (i != 0);
            do1(maco_pkg::OP_MUL, 2'(i), sa, sb, a, b, 7'h00, 7'h00, 4'h0,
                mulx(a, b, 2'(i), sa, sb));
            wr64(acc);
            do1(maco_pkg::OP_MACS, 2'h0, 1'b0, 1'b0, c, d, 7'h00, 7'h00,
                4'h0, laneAdd(acc, mulx(c, d, 2'(i), sa, sb), 2'(i)));
        end
    endtask

    task automatic t_vect_cplx();
        logic [31:0] a = 32'h8001_7FFF, b = 32'hFFFE_C003;
        logic [63:0] p, q;
        p = mulx(a, b, maco_pkg::SZ_16, 1'b1, 1'b1);
        q = mulx(a, {b[15:0], b[31:16]}, maco_pkg::SZ_16, 1'b1, 1'b1);
        do1(maco_pkg::OP_VECT, 2'h0, 1'b1, 1'b1, a, b, 7'h00, 7'h00, 4'h0,
            {p[63:32] + p[31:0], q[63:32] - q[31:0]});
        do1(maco_pkg::OP_CPLX, 2'h0, 1'b1, 1'b1, a, b, 7'h00, 7'h00, 4'h0,
            {p[63:32] - p[31:0], q[63:32] + q[31:0]});
    endtask

    task automatic t_macb();
        logic [63:0] v = 64'h1111_FFFF_2222_0003, e1, e2;
        do1(maco_pkg::OP_MUL, maco_pkg::SZ_16, 1'b0, 1'b0, 32'h0001_0001,
            32'h0001_0001, 7'h00, 7'h00, 4'h0,
            64'h0000_0001_0000_0001);
        wr64(v);
        st(7'h1E);
        wr64(64'h0);
        e1 = laneAdd(v, mulx(32'hFFFF_0102, 32'h0003_0304,
            maco_pkg::SZ_16, 1'b0, 1'b0), maco_pkg::SZ_16);
        e2 = mulx(32'h0100_0200, 32'h0300_0400, maco_pkg::SZ_16, 1'b0, 1'b0);
        do1(maco_pkg::OP_MACB, 2'h2, 1'b1, 1'b1, 32'hFFFF_0102,
            32'h0003_0304, 7'h1E, 7'h28, 4'b0111, e1);
        do1(maco_pkg::OP_MACB, 2'h2, 1'b1, 1'b1, 32'h0100_0200,
            32'h0300_0400, 7'h00, 7'h00, 4'b1010, e2);
        repeat (2) @(posedge core_clk);
        do1(maco_pkg::OP_LOAD, 2'h0, 1'b0, 1'b0, 32'h0, 32'h0, 7'h28,
            7'h00, 4'h0, e1);
        do1(maco_pkg::OP_LOAD, 2'h0, 1'b0, 1'b0, 32'h0, 32'h0, 7'h29,
            7'h00, 4'h0, e2);
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        mismatches++;
        test_done();
    end

    initial begin
        reset = 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        check({accumPart1, accumPart0}, 64'h0);
        check({63'h0, mValid}, 64'h0);
        check(mResult, 64'h0);
        t_store_load();
        t_step();
        t_mul_macs();
        t_vect_cplx();
        t_macb();
        test_done();
    end
endmodule
`default_nettype wire
